// ### hw/nxu_map.svh
`ifndef NXU_MAP_SVH
`define NXU_MAP_SVH

// Nibble register file positions, primary bank
`define NXU_NIB_ACC      4'h0
`define NXU_NIB_UPPER    4'h1
`define NXU_NIB_PTR_LO   4'h2
`define NXU_NIB_PTR_HI   4'h3
`define NXU_NIB_SEC_LO   4'h4
`define NXU_NIB_SEC_HI   4'h5
`define NXU_NIB_THR_LO   4'h6
`define NXU_NIB_THR_HI   4'h7

// Pair numbers on the operand select
`define NXU_PAIR_ACC     3'h0
`define NXU_PAIR_PTR     3'h1
`define NXU_PAIR_SEC     3'h2
`define NXU_PAIR_THR     3'h3

// Register reset value
`define NXU_NIB_RESET    4'h0

// Pointer step limits
`define NXU_WRAP_UP      4'h0
`define NXU_WRAP_DOWN    4'hF

// Last byte of a program memory page
`define NXU_PAGE_LAST    8'hFF

`endif

// ### hw/nxu_pkg.sv
package nxu_pkg;

  // Operations taken on the request port
  typedef enum logic [4:0] {
    OP_LD_IMM_PAIR = 5'h00,
    OP_LD_NIB_IND  = 5'h01,
    OP_ST_NIB_IND  = 5'h02,
    OP_LD_PAIR_IND = 5'h03,
    OP_ST_PAIR_IND = 5'h04,
    OP_LD_NIB_DIR  = 5'h05,
    OP_ST_NIB_DIR  = 5'h06,
    OP_LD_PAIR_DIR = 5'h07,
    OP_ST_PAIR_DIR = 5'h08,
    OP_MOV_REG_ACC = 5'h09,
    OP_MOV_ACC_REG = 5'h0A,
    OP_MOV_PR_ACC  = 5'h0B,
    OP_MOV_ACC_PR  = 5'h0C,
    OP_SWP_NIB_IND = 5'h0D,
    OP_SWP_PR_IND  = 5'h0E,
    OP_SWP_NIB_DIR = 5'h0F,
    OP_SWP_PR_DIR  = 5'h10,
    OP_SWP_REG     = 5'h11,
    OP_SWP_PAIR    = 5'h12,
    OP_TABLE_READ  = 5'h13
  } op_t;

  // Indirect pointer choices
  typedef enum logic [2:0] {
    PTR_PAIR     = 3'b000,
    PTR_PAIR_INC = 3'b001,
    PTR_PAIR_DEC = 3'b010,
    PTR_SECOND   = 3'b011,
    PTR_MIXED    = 3'b100
  } ptr_sel_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_LO_ADDR  = 4'b0001,
    ST_LO_DATA  = 4'b0010,
    ST_LO_WRITE = 4'b0011,
    ST_HI_ADDR  = 4'b0100,
    ST_HI_DATA  = 4'b0101,
    ST_HI_WRITE = 4'b0110,
    ST_TBL_ADDR = 4'b0111,
    ST_TBL_DATA = 4'b1000
  } state_t;

endpackage

// ### hw/pointer_stepper.sv
`timescale 1ns/1ps
`default_nettype none
`include "nxu_map.svh"

module pointer_stepper (
  input  wire logic [3:0] low_in,
  input  wire logic       down,
  output logic      [3:0] low_out,
  output logic            wrap
);

  // Step the pointer low nibble and flag the wrap value
  always_comb begin
    if (down) begin
      low_out = low_in - 4'h1;
      wrap    = (low_out == `NXU_WRAP_DOWN);
    end else begin
      low_out = low_in + 4'h1;
      wrap    = (low_out == `NXU_WRAP_UP);
    end
  end

endmodule // pointer_stepper
`default_nettype wire

// ### hw/nibble_transfer_exchange_unit.sv
// Operation
// - Immediate byte loads only second or third pair
// - Post-increment load skips when low nibble 0
// - Post-decrement load skips when low nibble F
// - Indirect nibble load has five pointer choices
// - Pointer pair load ignores pointer low bit
// - Pointer pair store forces low bit zero
// - Direct nibble load uses full byte address
// - Direct pair load takes even addresses only
// - Direct pair store uses even address, next
// - Any primary-bank nibble register copies into accumulator
// - Any pair, either bank, copies into acc_pair
// - acc_pair copies to any other pair
// - Indirect nibble swap with post-step skips
// - Pointer pair swap ignores pointer low bit
// - Direct pair swap on even address only
// - Nibble swap with seven non-accumulator registers
// - acc_pair swaps with any pair, either bank
// - Table read address: next byte's page, second_pair
// - Program counter is only read, never altered
// - Op at page end reads next page
`timescale 1ns/1ps
`default_nettype none
`include "nxu_map.svh"

module nibble_transfer_exchange_unit (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             OP_VALID,
  output logic                  OP_READY,
  input  wire nxu_pkg::op_t     OP_CODE,
  input  wire logic       [2:0] OP_SEL,
  input  wire logic       [7:0] OP_IMM,
  input  wire logic      [13:0] OP_PC,
  output logic                  DONE,
  output logic                  REFUSED,
  output logic                  SKIP_NEXT,
  output logic            [7:0] DM_ADDR,
  output logic                  DM_RE,
  output logic                  DM_WE,
  output logic            [3:0] DM_WDATA,
  input  wire logic       [3:0] DM_RDATA,
  output logic           [13:0] PM_ADDR,
  output logic                  PM_RE,
  input  wire logic       [7:0] PM_RDATA,
  output logic            [7:0] ACC_PAIR,
  output logic            [7:0] POINTER_PAIR,
  output logic            [7:0] SECOND_PAIR,
  output logic            [7:0] THIRD_PAIR
);

  nxu_pkg::state_t state_q;       // Sequencer state
  nxu_pkg::op_t    op_q;          // Operation in flight
  logic      [2:0] sel_q;         // Operand select in flight
  logic      [7:0] addr_q;        // Base data memory address
  logic      [3:0] nib_q [0:15];  // Both register banks
  logic      [7:0] dm_addr_q;     // Data memory address port
  logic            dm_re_q;       // Data memory read strobe
  logic            dm_we_q;       // Data memory write strobe
  logic      [3:0] dm_wdata_q;    // Data memory write data
  logic     [13:0] pm_addr_q;     // Program memory address
  logic            pm_re_q;       // Program memory read strobe
  logic            done_q;        // Completion pulse
  logic            refused_q;     // Refusal pulse
  logic            skip_q;        // Next request is skipped
  logic            accept;        // Request taken this cycle
  logic            legal;         // Request operands allowed
  logic      [7:0] eff_addr;      // Effective address of request
  logic     [13:0] pc_next;       // Address of following byte
  logic      [3:0] step_low;      // Stepped pointer low nibble
  logic            step_wrap;     // Stepped nibble hit the limit
  logic            step_now;      // Pointer step happens now

  // Memory operations that read before anything else
  function automatic logic is_read(input nxu_pkg::op_t op);
    case (op)
      nxu_pkg::OP_LD_NIB_IND, nxu_pkg::OP_LD_PAIR_IND,
      nxu_pkg::OP_LD_NIB_DIR, nxu_pkg::OP_LD_PAIR_DIR,
      nxu_pkg::OP_SWP_NIB_IND, nxu_pkg::OP_SWP_PR_IND,
      nxu_pkg::OP_SWP_NIB_DIR, nxu_pkg::OP_SWP_PR_DIR: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
  endfunction

  // Memory operations that only write
  function automatic logic is_store(input nxu_pkg::op_t op);
    case (op)
      nxu_pkg::OP_ST_NIB_IND, nxu_pkg::OP_ST_PAIR_IND,
      nxu_pkg::OP_ST_NIB_DIR, nxu_pkg::OP_ST_PAIR_DIR: is_store = 1'b1;
      default: is_store = 1'b0;
    endcase
  endfunction

  // Memory operations that also write back a read value
  function automatic logic is_swap(input nxu_pkg::op_t op);
    case (op)
      nxu_pkg::OP_SWP_NIB_IND, nxu_pkg::OP_SWP_PR_IND,
      nxu_pkg::OP_SWP_NIB_DIR, nxu_pkg::OP_SWP_PR_DIR: is_swap = 1'b1;
      default: is_swap = 1'b0;
    endcase
  endfunction

  // Memory operations on two nibbles
  function automatic logic is_pair(input nxu_pkg::op_t op);
    case (op)
      nxu_pkg::OP_LD_PAIR_IND, nxu_pkg::OP_ST_PAIR_IND,
      nxu_pkg::OP_LD_PAIR_DIR, nxu_pkg::OP_ST_PAIR_DIR,
      nxu_pkg::OP_SWP_PR_IND, nxu_pkg::OP_SWP_PR_DIR: is_pair = 1'b1;
      default: is_pair = 1'b0;
    endcase
  endfunction

  // Odd address of a pair
  function automatic logic [7:0] odd_of(input logic [7:0] a);
    odd_of = {a[7:1], 1'b1};
  endfunction

  assign accept    = OP_VALID && (state_q == nxu_pkg::ST_IDLE);
  assign OP_READY  = (state_q == nxu_pkg::ST_IDLE);
  assign pc_next   = OP_PC + 14'h0001;
  assign DONE      = done_q;
  assign REFUSED   = refused_q;
  assign SKIP_NEXT = skip_q;
  assign DM_ADDR   = dm_addr_q;
  assign DM_RE     = dm_re_q;
  assign DM_WE     = dm_we_q;
  assign DM_WDATA  = dm_wdata_q;
  assign PM_ADDR   = pm_addr_q;
  assign PM_RE     = pm_re_q;
  // Pair views of the primary bank
  assign ACC_PAIR     = {nib_q[`NXU_NIB_UPPER],  nib_q[`NXU_NIB_ACC]};
  assign POINTER_PAIR = {nib_q[`NXU_NIB_PTR_HI], nib_q[`NXU_NIB_PTR_LO]};
  assign SECOND_PAIR  = {nib_q[`NXU_NIB_SEC_HI], nib_q[`NXU_NIB_SEC_LO]};
  assign THIRD_PAIR   = {nib_q[`NXU_NIB_THR_HI], nib_q[`NXU_NIB_THR_LO]};

  // Operand checks on the request
  always_comb begin
    case (OP_CODE)
      nxu_pkg::OP_LD_IMM_PAIR:
        legal = (OP_SEL == `NXU_PAIR_SEC) || (OP_SEL == `NXU_PAIR_THR);
      nxu_pkg::OP_LD_NIB_IND, nxu_pkg::OP_SWP_NIB_IND:
        legal = (OP_SEL <= nxu_pkg::PTR_MIXED);
      nxu_pkg::OP_LD_PAIR_DIR:
        legal = !OP_IMM[0];
      nxu_pkg::OP_ST_PAIR_DIR:
        legal = !OP_IMM[0];
      nxu_pkg::OP_SWP_PR_DIR:
        legal = !OP_IMM[0];
      nxu_pkg::OP_MOV_ACC_PR:
        legal = (OP_SEL != `NXU_PAIR_ACC);
      nxu_pkg::OP_MOV_ACC_REG, nxu_pkg::OP_SWP_REG:
        legal = (OP_SEL != 3'h0);
      default:
        legal = 1'b1;
    endcase
  end

  // Effective data memory address of the request
  always_comb begin
    case (OP_CODE)
      nxu_pkg::OP_LD_NIB_IND, nxu_pkg::OP_SWP_NIB_IND: begin
        case (OP_SEL)
          nxu_pkg::PTR_SECOND: eff_addr = SECOND_PAIR;
          nxu_pkg::PTR_MIXED:
            eff_addr = {nib_q[`NXU_NIB_SEC_HI], nib_q[`NXU_NIB_PTR_LO]};
          default: eff_addr = POINTER_PAIR;
        endcase
      end
      nxu_pkg::OP_LD_PAIR_IND, nxu_pkg::OP_ST_PAIR_IND,
      nxu_pkg::OP_SWP_PR_IND:
        eff_addr = {POINTER_PAIR[7:1], 1'b0};
      nxu_pkg::OP_LD_NIB_DIR, nxu_pkg::OP_ST_NIB_DIR,
      nxu_pkg::OP_SWP_NIB_DIR, nxu_pkg::OP_LD_PAIR_DIR,
      nxu_pkg::OP_ST_PAIR_DIR, nxu_pkg::OP_SWP_PR_DIR:
        eff_addr = OP_IMM;
      default:
        eff_addr = POINTER_PAIR;
    endcase
  end

  // Pointer step at the end of a post-step nibble access
  assign step_now = ((sel_q == nxu_pkg::PTR_PAIR_INC) ||
                     (sel_q == nxu_pkg::PTR_PAIR_DEC)) &&
                    (((state_q == nxu_pkg::ST_LO_DATA) &&
                      (op_q == nxu_pkg::OP_LD_NIB_IND)) ||
                     ((state_q == nxu_pkg::ST_LO_WRITE) &&
                      (op_q == nxu_pkg::OP_SWP_NIB_IND)));

  pointer_stepper u_step (
    .low_in  (nib_q[`NXU_NIB_PTR_LO]),
    .down    (sel_q == nxu_pkg::PTR_PAIR_DEC),
    .low_out (step_low),
    .wrap    (step_wrap)
  );

  // Sequencer and memory strobes
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q    <= nxu_pkg::ST_IDLE;
      op_q       <= nxu_pkg::OP_LD_IMM_PAIR;
      sel_q      <= 3'h0;
      addr_q     <= 8'h00;
      dm_addr_q  <= 8'h00;
      dm_re_q    <= 1'b0;
      dm_we_q    <= 1'b0;
      dm_wdata_q <= 4'h0;
      pm_addr_q  <= 14'h0000;
      pm_re_q    <= 1'b0;
      done_q     <= 1'b0;
      refused_q  <= 1'b0;
    end else begin
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      dm_re_q   <= 1'b0;
      dm_we_q   <= 1'b0;
      pm_re_q   <= 1'b0;
      case (state_q)
        nxu_pkg::ST_IDLE: if (accept) begin
          op_q   <= OP_CODE;
          sel_q  <= OP_SEL;
          addr_q <= eff_addr;
          if (skip_q) begin
            done_q <= 1'b1;
          end else if (!legal) begin
            done_q    <= 1'b1;
            refused_q <= 1'b1;
          end else if (OP_CODE == nxu_pkg::OP_TABLE_READ) begin
            // Page of the next byte covers the page-end case
            pm_addr_q <= {pc_next[13:8], SECOND_PAIR};
            pm_re_q   <= 1'b1;
            state_q   <= nxu_pkg::ST_TBL_ADDR;
          end else if (is_read(OP_CODE)) begin
            dm_addr_q <= eff_addr;
            dm_re_q   <= 1'b1;
            state_q   <= nxu_pkg::ST_LO_ADDR;
          end else if (is_store(OP_CODE)) begin
            dm_addr_q  <= eff_addr;
            dm_wdata_q <= nib_q[`NXU_NIB_ACC];
            dm_we_q    <= 1'b1;
            state_q    <= nxu_pkg::ST_LO_WRITE;
          end else begin
            done_q <= 1'b1; // Register-only work completes here
          end
        end
        nxu_pkg::ST_LO_ADDR: state_q <= nxu_pkg::ST_LO_DATA;
        nxu_pkg::ST_LO_DATA: begin
          if (is_swap(op_q)) begin
            // Old accumulator goes back to the same location
            dm_addr_q  <= addr_q;
            dm_wdata_q <= nib_q[`NXU_NIB_ACC];
            dm_we_q    <= 1'b1;
            state_q    <= nxu_pkg::ST_LO_WRITE;
          end else if (is_pair(op_q)) begin
            dm_addr_q <= odd_of(addr_q);
            dm_re_q   <= 1'b1;
            state_q   <= nxu_pkg::ST_HI_ADDR;
          end else begin
            done_q  <= 1'b1;
            state_q <= nxu_pkg::ST_IDLE;
          end
        end
        nxu_pkg::ST_LO_WRITE: begin
          if (is_pair(op_q) && is_swap(op_q)) begin
            dm_addr_q <= odd_of(addr_q);
            dm_re_q   <= 1'b1;
            state_q   <= nxu_pkg::ST_HI_ADDR;
          end else if (is_pair(op_q)) begin
            dm_addr_q  <= odd_of(addr_q);
            dm_wdata_q <= nib_q[`NXU_NIB_UPPER];
            dm_we_q    <= 1'b1;
            state_q    <= nxu_pkg::ST_HI_WRITE;
          end else begin
            done_q  <= 1'b1;
            state_q <= nxu_pkg::ST_IDLE;
          end
        end
        nxu_pkg::ST_HI_ADDR: state_q <= nxu_pkg::ST_HI_DATA;
        nxu_pkg::ST_HI_DATA: begin
          if (is_swap(op_q)) begin
            dm_wdata_q <= nib_q[`NXU_NIB_UPPER];
            dm_we_q    <= 1'b1;
            state_q    <= nxu_pkg::ST_HI_WRITE;
          end else begin
            done_q  <= 1'b1;
            state_q <= nxu_pkg::ST_IDLE;
          end
        end
        nxu_pkg::ST_HI_WRITE: begin
          done_q  <= 1'b1;
          state_q <= nxu_pkg::ST_IDLE;
        end
        nxu_pkg::ST_TBL_ADDR: state_q <= nxu_pkg::ST_TBL_DATA;
        nxu_pkg::ST_TBL_DATA: begin
          done_q  <= 1'b1;
          state_q <= nxu_pkg::ST_IDLE;
        end
        default: state_q <= nxu_pkg::ST_IDLE;
      endcase
    end
  end

  // Skip flag: set by a wrapping post step, spent by the next request
  always_ff @(posedge CLK) begin
    if (RST) begin
      skip_q <= 1'b0;
    end else if (step_now) begin
      skip_q <= step_wrap;
    end else if (accept && skip_q) begin
      skip_q <= 1'b0;
    end
  end

  // Register banks; no carry lives here, so none is touched
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < 16; i++) begin
        nib_q[i] <= `NXU_NIB_RESET;
      end
    end else begin
      case (state_q)
        nxu_pkg::ST_IDLE: if (accept && !skip_q && legal) begin
          case (OP_CODE)
            nxu_pkg::OP_LD_IMM_PAIR: begin
              nib_q[{OP_SEL, 1'b0}] <= OP_IMM[3:0];
              nib_q[{OP_SEL, 1'b1}] <= OP_IMM[7:4];
            end
            nxu_pkg::OP_MOV_REG_ACC:
              nib_q[`NXU_NIB_ACC] <= nib_q[{1'b0, OP_SEL}];
            nxu_pkg::OP_MOV_ACC_REG:
              nib_q[{1'b0, OP_SEL}] <= nib_q[`NXU_NIB_ACC];
            nxu_pkg::OP_MOV_PR_ACC: begin
              nib_q[`NXU_NIB_ACC]   <= nib_q[{OP_SEL, 1'b0}];
              nib_q[`NXU_NIB_UPPER] <= nib_q[{OP_SEL, 1'b1}];
            end
            nxu_pkg::OP_MOV_ACC_PR: begin
              nib_q[{OP_SEL, 1'b0}] <= nib_q[`NXU_NIB_ACC];
              nib_q[{OP_SEL, 1'b1}] <= nib_q[`NXU_NIB_UPPER];
            end
            nxu_pkg::OP_SWP_REG: begin
              nib_q[`NXU_NIB_ACC]   <= nib_q[{1'b0, OP_SEL}];
              nib_q[{1'b0, OP_SEL}] <= nib_q[`NXU_NIB_ACC];
            end
            nxu_pkg::OP_SWP_PAIR: begin
              nib_q[`NXU_NIB_ACC]   <= nib_q[{OP_SEL, 1'b0}];
              nib_q[`NXU_NIB_UPPER] <= nib_q[{OP_SEL, 1'b1}];
              nib_q[{OP_SEL, 1'b0}] <= nib_q[`NXU_NIB_ACC];
              nib_q[{OP_SEL, 1'b1}] <= nib_q[`NXU_NIB_UPPER];
            end
            default: ;
          endcase
        end
        nxu_pkg::ST_LO_DATA: begin
          nib_q[`NXU_NIB_ACC] <= DM_RDATA;
          if (step_now) begin
            nib_q[`NXU_NIB_PTR_LO] <= step_low;
          end
        end
        nxu_pkg::ST_LO_WRITE: if (step_now) begin
          nib_q[`NXU_NIB_PTR_LO] <= step_low;
        end
        nxu_pkg::ST_HI_DATA:
          nib_q[`NXU_NIB_UPPER] <= DM_RDATA;
        nxu_pkg::ST_TBL_DATA: begin
          nib_q[`NXU_NIB_ACC]   <= PM_RDATA[3:0];
          nib_q[`NXU_NIB_UPPER] <= PM_RDATA[7:4];
        end
        default: ;
      endcase
    end
  end

  // Post-increment load reports the wrap to zero with its completion
  inc_skip_a: assert property (@(posedge CLK) disable iff (RST)
    DONE && op_q == nxu_pkg::OP_LD_NIB_IND &&
    sel_q == nxu_pkg::PTR_PAIR_INC && !$past(skip_q)
    |-> SKIP_NEXT == (POINTER_PAIR[3:0] == `NXU_WRAP_UP))
    else $error("post-increment skip wrong");

  // Post-decrement swap reports the wrap to F
  dec_skip_a: assert property (@(posedge CLK) disable iff (RST)
    DONE && op_q == nxu_pkg::OP_SWP_NIB_IND &&
    sel_q == nxu_pkg::PTR_PAIR_DEC && !$past(skip_q)
    |-> SKIP_NEXT == (POINTER_PAIR[3:0] == `NXU_WRAP_DOWN))
    else $error("post-decrement skip wrong");

  // Pointer pair load starts on the even nibble
  pair_even_a: assert property (@(posedge CLK) disable iff (RST)
    state_q == nxu_pkg::ST_LO_ADDR && op_q == nxu_pkg::OP_LD_PAIR_IND
    |-> DM_ADDR == {POINTER_PAIR[7:1], 1'b0})
    else $error("pair address not even");

  // Pair store puts the upper nibble at the odd address
  store_hi_a: assert property (@(posedge CLK) disable iff (RST)
    state_q == nxu_pkg::ST_HI_WRITE && is_store(op_q) && is_pair(op_q)
    |-> DM_WE && DM_ADDR[0] && DM_WDATA == ACC_PAIR[7:4])
    else $error("pair store upper half wrong");

  // Odd direct pair load is refused and changes nothing
  odd_refuse_a: assert property (@(posedge CLK) disable iff (RST)
    accept && !skip_q && OP_CODE == nxu_pkg::OP_LD_PAIR_DIR && OP_IMM[0]
    |=> REFUSED && DONE && $stable(ACC_PAIR) && !DM_RE)
    else $error("odd direct pair not refused");

  // Move onto acc_pair itself is refused
  self_move_a: assert property (@(posedge CLK) disable iff (RST)
    accept && !skip_q && OP_CODE == nxu_pkg::OP_MOV_ACC_PR &&
    OP_SEL == `NXU_PAIR_ACC |=> REFUSED)
    else $error("move to acc_pair not refused");

  // Immediate byte lands in the second pair
  imm_load_a: assert property (@(posedge CLK) disable iff (RST)
    accept && !skip_q && OP_CODE == nxu_pkg::OP_LD_IMM_PAIR &&
    OP_SEL == `NXU_PAIR_SEC |=> SECOND_PAIR == $past(OP_IMM) && DONE)
    else $error("immediate pair load wrong");

  // Table read at a page end fetches from the next page
  page_end_a: assert property (@(posedge CLK) disable iff (RST)
    accept && !skip_q && OP_CODE == nxu_pkg::OP_TABLE_READ &&
    OP_PC[7:0] == `NXU_PAGE_LAST
    |=> PM_RE && PM_ADDR[13:8] == $past(OP_PC[13:8]) + 6'h01
        && PM_ADDR[7:0] == SECOND_PAIR)
    else $error("table page wrong");

  // Table data lands in acc_pair two cycles after the strobe
  table_data_a: assert property (@(posedge CLK) disable iff (RST)
    PM_RE |-> ##2 DONE && ACC_PAIR == $past(PM_RDATA))
    else $error("table data not loaded");

  // A skipped request is spent with no effect
  skip_none_a: assert property (@(posedge CLK) disable iff (RST)
    accept && skip_q
    |=> DONE && !SKIP_NEXT && !DM_WE && !DM_RE && !PM_RE &&
        $stable(ACC_PAIR) && $stable(POINTER_PAIR))
    else $error("skipped request had an effect");

endmodule // nibble_transfer_exchange_unit
`default_nettype wire

// ### tb/nxu_memories.sv
`timescale 1ns/1ps
`default_nettype none

// Data and program memory seen across the unit's memory ports
module nxu_memories (
  input  wire logic        clk,
  input  wire logic  [7:0] dm_addr,
  input  wire logic        dm_re,
  input  wire logic        dm_we,
  input  wire logic  [3:0] dm_wdata,
  output logic       [3:0] dm_rdata,
  input  wire logic [13:0] pm_addr,
  input  wire logic        pm_re,
  output logic       [7:0] pm_rdata
);
  logic [3:0] dm [256];  // Nibble data memory

  // Known pattern so every read has a checkable value
  initial begin
    dm_rdata = 4'h0;
    pm_rdata = 8'h00;
    foreach (dm[i]) dm[i] = 4'(i * 7 + 3);
  end

  // Read data valid the cycle after the strobe, then churns
  always @(posedge clk) begin
    if (dm_we) dm[dm_addr] <= dm_wdata;
    dm_rdata <= dm_re ? dm[dm_addr] : ~dm_rdata;
    pm_rdata <= pm_re ? 8'(pm_addr * 13 + (pm_addr >> 8) * 5) : ~pm_rdata;
  end
endmodule // nxu_memories

`default_nettype wire

// ### tb/tb_nibble_transfer_exchange_unit.sv
`timescale 1ns/1ps
`default_nettype none

module tb_nibble_transfer_exchange_unit;
  logic CLK = 0, RST = 1, OP_VALID = 0;
  nxu_pkg::op_t OP_CODE = nxu_pkg::OP_LD_IMM_PAIR;
  logic [2:0] OP_SEL = 3'h0;
  logic [7:0] OP_IMM = 8'h00;
  logic [13:0] OP_PC = 14'h0000;
  logic OP_READY, DONE, REFUSED, SKIP_NEXT, DM_RE, DM_WE, PM_RE;
  logic [7:0] DM_ADDR, PM_RDATA, ACC_PAIR, POINTER_PAIR;
  logic [7:0] SECOND_PAIR, THIRD_PAIR;
  logic [3:0] DM_WDATA, DM_RDATA;
  logic [13:0] PM_ADDR;
  int r[16], dm[256], skp, err_count, compares;  // Reference state

  nibble_transfer_exchange_unit nibble_transfer_exchange_unit_i (.CLK,
    .RST, .OP_VALID, .OP_READY, .OP_CODE, .OP_SEL, .OP_IMM, .OP_PC,
    .DONE, .REFUSED, .SKIP_NEXT, .DM_ADDR, .DM_RE, .DM_WE, .DM_WDATA,
    .DM_RDATA, .PM_ADDR, .PM_RE, .PM_RDATA, .ACC_PAIR, .POINTER_PAIR,
    .SECOND_PAIR, .THIRD_PAIR);
  nxu_memories nxu_memories_i (.clk(CLK), .dm_addr(DM_ADDR),
    .dm_re(DM_RE), .dm_we(DM_WE), .dm_wdata(DM_WDATA),
    .dm_rdata(DM_RDATA), .pm_addr(PM_ADDR), .pm_re(PM_RE),
    .pm_rdata(PM_RDATA));

  // 200 MHz clock
  initial forever #2.5 CLK = ~CLK;

  // Pair value: 0..3 primary, 4..7 alternate bank
  function automatic int pr(input int p);
    return r[2 * p + 1] * 16 + r[2 * p];
  endfunction
  function automatic void wp(input int p, input int v);
    r[2 * p] = v & 15;
    r[2 * p + 1] = (v >> 4) & 15;
  endfunction
  function automatic int pm(input int a);
    return (a * 13 + (a >> 8) * 5) & 255;
  endfunction

  // Pair load, store or swap at an even address
  task automatic xf(input int a, input int o);
    int t, u, ra, rx;
    t = dm[a]; u = dm[a + 1]; ra = r[0]; rx = r[1];
    if (o != 4 && o != 8) begin r[0] = t; r[1] = u; end
    if (o != 3 && o != 7) begin dm[a] = ra; dm[a + 1] = rx; end
  endtask

  // Behavioural model of one request
  task automatic mdl(input int o, s, m, pc, output int rf);
    int a, t, st;
    rf = 0; st = 0;
    if (skp) begin skp = 0; return; end
    case (o)
      0: if (s == 2 || s == 3) wp(s, m); else rf = 1;
      1, 13: if (s > 4) rf = 1; else begin
        a = (s == 3) ? pr(2) : (s == 4) ? r[5] * 16 + r[2] : pr(1);
        t = r[0]; r[0] = dm[a];
        if (o == 13) dm[a] = t;
        st = s;
      end
      2: dm[pr(1)] = r[0];
      3, 4, 14: xf(pr(1) & 'hfe, o);
      5: r[0] = dm[m];
      6: dm[m] = r[0];
      15: begin t = r[0]; r[0] = dm[m]; dm[m] = t; end
      7, 8, 16: if (m & 1) rf = 1; else xf(m, o);
      9: r[0] = r[s];
      10, 17: if (s == 0) rf = 1; else begin
        t = r[0]; r[0] = (o == 17) ? r[s] : r[0]; r[s] = t;
      end
      11: wp(0, pr(s));
      12: if (s == 0) rf = 1; else wp(s, pr(0));
      18: begin t = pr(0); wp(0, pr(s)); wp(s, t); end
      default: wp(0, pm(((pc + 1) & 'h3f00) | pr(2)));
    endcase
    if (st == 1) begin r[2] = (r[2] + 1) & 15; skp = r[2] == 0; end
    if (st == 2) begin r[2] = (r[2] + 15) & 15; skp = r[2] == 15; end
  endtask

  task automatic chk1(input logic g, input int e);
    compares++;
    if (g !== 1'(e)) begin
      err_count++;
      $display("BAD %0t flag %b want %0d", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input int e);
    compares++;
    if (g !== 8'(e)) begin
      err_count++;
      $display("BAD %0t pair %h want %h", $time, g, 8'(e));
    end
  endtask

  // Compare every visible result with the model
  task automatic check_all(input int rf);
    chk1(REFUSED, rf);
    chk1(SKIP_NEXT, skp);
    chk8(ACC_PAIR, pr(0));
    chk8(POINTER_PAIR, pr(1));
    chk8(SECOND_PAIR, pr(2));
    chk8(THIRD_PAIR, pr(3));
  endtask

  // One request, held until taken, then wait for completion
  task automatic run_op(input int o, s, m, pc);
    int rf, k;
    @(posedge CLK); #1;
    OP_VALID = 1; OP_CODE = nxu_pkg::op_t'(5'(o)); OP_SEL = 3'(s);
    OP_IMM = 8'(m); OP_PC = 14'(pc);
    k = 0;
    while (OP_READY !== 1'b1 && k < 10) begin @(posedge CLK); #1; k++; end
    @(posedge CLK);
    #1 OP_VALID = 0;
    mdl(o, s, m, pc, rf);
    k = 0;
    while (DONE !== 1'b1 && k < 12) begin @(posedge CLK); #1; k++; end
    chk1(DONE, 1);
    check_all(rf);
  endtask

  task automatic complete_run;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Random requests, page-end program counters mixed in
  initial begin
    int o, s, m, pc;
    void'($urandom(31));
    foreach (dm[i]) dm[i] = (i * 7 + 3) & 15;
    repeat (10) @(posedge CLK);
    #1 RST = 0;
    check_all(0);
    for (int i = 0; i < 700; i++) begin
      o = $urandom % 20; s = $urandom % 8;
      m = $urandom % 256; pc = $urandom & 'h3fff;
      if (i % 4 == 0) pc = pc | 'hff;
      run_op(o, s, m, pc);
    end
    foreach (dm[i]) chk8(8'(nxu_memories_i.dm[i]), dm[i]);
    complete_run;
  end

  // Hang guard
  initial begin
    #60000;
    err_count++;
    complete_run;
  end
endmodule // tb_nibble_transfer_exchange_unit

`default_nettype wire
